/* File: design/spbm_apb_regs.sv */
// APB slave holding the setup register and reflecting the memory status.
// Assumes an APB master on the same clock; one wait state per transfer.
module spbm_apb_regs (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [spbm_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Block side
  output logic      [31:0]                  cfg,
  input  wire logic [31:0]                  status
);

  logic [31:0] cfg_reg, cfg_next, rdata_reg, rdata_next;
  logic        ack_reg, ack_next, err_reg, err_next;
  logic        mapped;

  // ----------------------------------------------------------------
  // Decode and answer; data is prepared in the wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    mapped     = (paddr == spbm_pkg::CFG_OFF) || (paddr == spbm_pkg::STAT_OFF);
    ack_next   = psel && penable && !ack_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    cfg_next   = cfg_reg;
    if (ack_next) begin
      err_next   = !mapped;  // Unmapped address answers with an error
      rdata_next = 32'h0000_0000;
      if (!pwrite && paddr == spbm_pkg::CFG_OFF) begin
        rdata_next = cfg_reg;
      end else if (!pwrite && paddr == spbm_pkg::STAT_OFF) begin
        rdata_next = status;
      end
    end
    // Write lands only on the edge that samples pready high
    if (ack_reg && psel && penable && pwrite && paddr == spbm_pkg::CFG_OFF) begin
      cfg_next = pwdata & spbm_pkg::CFG_WR_MASK;
    end
  end

  // Register stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg   <= spbm_pkg::CFG_RESET;
      rdata_reg <= 32'h0000_0000;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      cfg_reg   <= cfg_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next;
    end
  end

  assign cfg     = cfg_reg;
  assign prdata  = rdata_reg;
  assign pready  = ack_reg;
  assign pslverr = err_reg;

endmodule

/* File: design/spbm_array.sv */
// Storage array: 512 rows of 36 flip-flops with a per-bit write mask.
// Assumes the caller registers row, mask and data; the read is combinational.
module spbm_array #(
  parameter logic [spbm_pkg::ROWS*spbm_pkg::ROW_W-1:0] INIT_CONTENT = '0
) (
  // Clock and power-on reset
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  // Access
  input  wire logic                           wr_en,
  input  wire logic [spbm_pkg::ROW_IDX_W-1:0] row,
  input  wire logic [spbm_pkg::ROW_W-1:0]     wr_mask,
  input  wire logic [spbm_pkg::ROW_W-1:0]     wr_bits,
  output logic      [spbm_pkg::ROW_W-1:0]     rd_bits
);

  logic [spbm_pkg::ROW_W-1:0] words [spbm_pkg::ROWS];

  // ----------------------------------------------------------------
  // One row per entry; only power-on reset loads the preset contents
  // ----------------------------------------------------------------
  for (genvar r = 0; r < spbm_pkg::ROWS; r++) begin : g_row
    logic [spbm_pkg::ROW_W-1:0] word_reg;
    logic [spbm_pkg::ROW_W-1:0] word_next;

    // Masked merge keeps the other lanes of the row intact
    always_comb begin
      word_next = word_reg;
      if (wr_en && row == spbm_pkg::ROW_IDX_W'(r)) begin
        word_next = (word_reg & ~wr_mask) | (wr_bits & wr_mask);
      end
    end

    // Register clears never reach here, so contents survive them
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        word_reg <= INIT_CONTENT[r*spbm_pkg::ROW_W +: spbm_pkg::ROW_W];
      end else begin
        word_reg <= word_next;
      end
    end

    assign words[r] = word_reg;
  end

  // Read port
  assign rd_bits = words[row];

endmodule

/* File: design/spbm_pkg.sv */
// Shared constants for the single-port block memory and its setup registers.
// Assumes a single 40 MHz clock domain; all users refer to names as spbm_pkg::name.
package spbm_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int MEM_BITS  = 16384;  // Data cells, ninth bits of the x9 shapes not counted
  localparam int ROWS      = 512;
  localparam int ROW_W     = 36;
  localparam int ROW_IDX_W = 9;
  localparam int ADDR_W    = 14;
  localparam int DATA_W    = 36;
  localparam int LANE_W    = 5;
  localparam int SRC_W     = 6;
  localparam int SEL_W     = 3;
  localparam int SLOT_W    = 9;      // Bits per slot in the x9 family
  localparam int PAR_POS   = 8;      // Ninth bit of a slot, unused by narrow shapes

  // ----------------------------------------------------------------
  // Shapes, width masks and write modes
  // ----------------------------------------------------------------
  localparam logic [2:0] SHAPE_X1  = 3'h0;
  localparam logic [2:0] SHAPE_X2  = 3'h1;
  localparam logic [2:0] SHAPE_X4  = 3'h2;
  localparam logic [2:0] SHAPE_X9  = 3'h3;
  localparam logic [2:0] SHAPE_X18 = 3'h4;
  localparam logic [2:0] SHAPE_X36 = 3'h5;
  localparam logic [35:0] MASK_X1  = 36'h0_0000_0001;
  localparam logic [35:0] MASK_X2  = 36'h0_0000_0003;
  localparam logic [35:0] MASK_X4  = 36'h0_0000_000F;
  localparam logic [35:0] MASK_X9  = 36'h0_0000_01FF;
  localparam logic [35:0] MASK_X18 = 36'h0_0003_FFFF;
  localparam logic [35:0] MASK_X36 = 36'hF_FFFF_FFFF;
  typedef enum logic [1:0] {WM_NORMAL, WM_WRITE_THROUGH, WM_READ_BEFORE_WRITE} spbm_wmode_t;
  localparam logic [SEL_W-1:0] SEL_DECODE_DEF = 3'h0;

  // ----------------------------------------------------------------
  // Register map (APB, byte addresses)
  // ----------------------------------------------------------------
  localparam int          PADDR_W       = 12;
  localparam logic [11:0] CFG_OFF       = 12'h000;
  localparam logic [11:0] STAT_OFF      = 12'h004;
  localparam int          CFG_OUTSTG    = 0;
  localparam int          CFG_SYNC      = 1;
  localparam int          CFG_GSR       = 2;
  localparam int          CFG_WM_LSB    = 3;
  localparam int          CFG_SHAPE_LSB = 5;
  localparam logic [31:0] CFG_RESET     = 32'h0000_0004;
  localparam logic [31:0] CFG_WR_MASK   = 32'h0000_00FF;
  localparam int          STAT_PEND     = 0;
  localparam int          STAT_HIT      = 1;
  localparam int          STAT_SEL_LSB  = 2;

endpackage

/* File: design/spbm_top.sv */
// Single-port block memory: registered inputs, shape-dependent lanes, three
// write modes, optional output stage and a configurable register clear.
// Assumes fabric logic on the same clock drives the memory pins synchronously.
//
// Overview of operation
// - Address, write data and strobe are registered before the array is touched.
// - Read data leaves directly or through an optional output stage; direct by default.
// - Every register updates on the rising clock edge.
// - Clock enable and write strobe are active high; enable low holds the input registers.
// - Register clear is active high and requests a reset.
// - Register clear empties input and output registers, never the stored contents.
// - Register clear acts asynchronously by default, or synchronously when selected.
// - A setup bit, on by default, lets the global preset reset the registers.
// - The 3-bit bank select acts as top address bits for up to eight blocks.
// - Each block holds 16,384 data bits; larger memories cascade blocks.
// - Shapes 16Kx1 to 512x36 are supported; one bit wide after reset.
// - Write modes normal, read-before-write and write-through; normal by default.
// - Contents may be preset; without a preset the array starts all zero.
module spbm_top #(
  parameter logic [spbm_pkg::SEL_W-1:0]                SEL_DECODE   = spbm_pkg::SEL_DECODE_DEF,
  parameter logic [spbm_pkg::ROWS*spbm_pkg::ROW_W-1:0] INIT_CONTENT = '0
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  // Memory port from fabric
  input  wire logic                         clock_en,
  input  wire logic                         write_strobe,
  input  wire logic [spbm_pkg::ADDR_W-1:0]  mem_addr,
  input  wire logic [spbm_pkg::DATA_W-1:0]  write_word,
  input  wire logic [spbm_pkg::SEL_W-1:0]   bank_sel,
  output logic      [spbm_pkg::DATA_W-1:0]  read_word,
  // Register clears
  input  wire logic                         reg_clear,
  input  wire logic                         global_preset,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [spbm_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]                    cfg, status;
  logic                           cfg_outstg, cfg_sync, cfg_gsr;
  spbm_pkg::spbm_wmode_t          cfg_wm;
  logic [2:0]                     shape_c;
  logic                           clear_req, arst_n;
  logic [spbm_pkg::ADDR_W-1:0]    addr_reg, addr_next;
  logic [spbm_pkg::DATA_W-1:0]    wd_reg, wd_next;
  logic                           we_reg, we_next, pend_reg, pend_next;
  logic [spbm_pkg::SEL_W-1:0]     sel_reg, sel_next;
  logic [spbm_pkg::DATA_W-1:0]    dout_reg, dout_next, q_reg, q_next;
  logic                           hit_reg, hit_next;
  logic                           hit_c, arr_wr_en;
  logic [spbm_pkg::ROW_IDX_W-1:0] row_c;
  logic [spbm_pkg::LANE_W-1:0]    lane_c;
  logic [spbm_pkg::DATA_W-1:0]    width_mask_c, wd_masked_c, rd_word_c;
  logic [spbm_pkg::ROW_W-1:0]     in_lane_c, wr_bits_c, row_rdata;
  logic [spbm_pkg::SRC_W-1:0]     src_c [spbm_pkg::ROW_W];

  // ----------------------------------------------------------------
  // Setup register and status
  // ----------------------------------------------------------------
  spbm_apb_regs u_regs (
    .clock   (clock),
    .rst_n   (rst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .cfg     (cfg),
    .status  (status)
  );

  // Field extraction; an unused write-mode code falls back to normal
  always_comb begin
    cfg_outstg = cfg[spbm_pkg::CFG_OUTSTG];
    cfg_sync   = cfg[spbm_pkg::CFG_SYNC];
    cfg_gsr    = cfg[spbm_pkg::CFG_GSR];
    shape_c    = cfg[spbm_pkg::CFG_SHAPE_LSB +: 3];
    cfg_wm     = spbm_pkg::WM_NORMAL;
    if (cfg[spbm_pkg::CFG_WM_LSB +: 2] == 2'h1) begin
      cfg_wm = spbm_pkg::WM_WRITE_THROUGH;
    end else if (cfg[spbm_pkg::CFG_WM_LSB +: 2] == 2'h2) begin
      cfg_wm = spbm_pkg::WM_READ_BEFORE_WRITE;
    end
  end

  // Status word seen by software
  always_comb begin
    status = 32'h0000_0000;
    status[spbm_pkg::STAT_PEND] = pend_reg;
    status[spbm_pkg::STAT_HIT]  = hit_reg;
    status[spbm_pkg::STAT_SEL_LSB +: spbm_pkg::SEL_W] = SEL_DECODE;
  end

  // ----------------------------------------------------------------
  // Clear paths
  // ----------------------------------------------------------------
  // Global preset joins the clear only when allowed; async mode drives the reset pin
  always_comb begin
    clear_req = reg_clear || (cfg_gsr && global_preset);
    arst_n    = rst_n && !(!cfg_sync && clear_req);
  end

  // ----------------------------------------------------------------
  // Shape decode: row index, lane and width of the selected word
  // ----------------------------------------------------------------
  // Codes above x36 behave as x36 so the array is never addressed oddly
  always_comb begin
    unique case (shape_c)
      spbm_pkg::SHAPE_X1: begin
        row_c        = addr_reg[13:5];
        lane_c       = addr_reg[4:0];
        width_mask_c = spbm_pkg::MASK_X1;
      end
      spbm_pkg::SHAPE_X2: begin
        row_c        = addr_reg[12:4];
        lane_c       = {1'b0, addr_reg[3:0]};
        width_mask_c = spbm_pkg::MASK_X2;
      end
      spbm_pkg::SHAPE_X4: begin
        row_c        = addr_reg[11:3];
        lane_c       = {2'h0, addr_reg[2:0]};
        width_mask_c = spbm_pkg::MASK_X4;
      end
      spbm_pkg::SHAPE_X9: begin
        row_c        = addr_reg[10:2];
        lane_c       = {3'h0, addr_reg[1:0]};
        width_mask_c = spbm_pkg::MASK_X9;
      end
      spbm_pkg::SHAPE_X18: begin
        row_c        = addr_reg[9:1];
        lane_c       = {4'h0, addr_reg[0]};
        width_mask_c = spbm_pkg::MASK_X18;
      end
      default: begin
        row_c        = addr_reg[8:0];
        lane_c       = 5'h00;
        width_mask_c = spbm_pkg::MASK_X36;
      end
    endcase
    wd_masked_c = wd_reg & width_mask_c;
  end

  // Per row bit: does it belong to the lane, and which word bit feeds it
  for (genvar j = 0; j < spbm_pkg::ROW_W; j++) begin : g_bit
    localparam int JD = j / spbm_pkg::SLOT_W;
    localparam int JM = j % spbm_pkg::SLOT_W;
    localparam int P  = j - JD;
    always_comb begin
      logic [2:0] k;
      k = 3'h0;
      if (shape_c <= spbm_pkg::SHAPE_X4) begin
        // Narrow shapes skip the ninth bits: 16,384 data cells in use
        in_lane_c[j] = (JM != spbm_pkg::PAR_POS) &&
                       ((spbm_pkg::LANE_W'(P) >> shape_c) == lane_c);
        src_c[j]     = spbm_pkg::SRC_W'(P) & ((6'h01 << shape_c) - 6'h01);
      end else begin
        k = (shape_c > spbm_pkg::SHAPE_X36) ? 3'h2 : shape_c - spbm_pkg::SHAPE_X9;
        in_lane_c[j] = (spbm_pkg::LANE_W'(JD) >> k) == lane_c;
        src_c[j]     = spbm_pkg::SRC_W'(JM) +
                       spbm_pkg::SRC_W'(3'(JD) & ((3'h1 << k) - 3'h1)) * 6'h09;
      end
      wr_bits_c[j] = wd_reg[src_c[j]];
    end
  end

  // Gather the addressed word out of the row
  always_comb begin
    rd_word_c = '0;
    for (int j = 0; j < spbm_pkg::ROW_W; j++) begin
      if (in_lane_c[j]) begin
        rd_word_c[src_c[j]] = row_rdata[j];
      end
    end
  end

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------
  // A clear in the access cycle cancels the write, leaving contents alone
  always_comb begin
    hit_c     = pend_reg && (sel_reg == SEL_DECODE);
    arr_wr_en = hit_c && we_reg && !clear_req;
  end

  spbm_array #(
    .INIT_CONTENT (INIT_CONTENT)
  ) u_array (
    .clock   (clock),
    .rst_n   (rst_n),
    .wr_en   (arr_wr_en),
    .row     (row_c),
    .wr_mask (in_lane_c),
    .wr_bits (wr_bits_c),
    .rd_bits (row_rdata)
  );

  // ----------------------------------------------------------------
  // Pipeline: input stage, access stage, optional output stage
  // ----------------------------------------------------------------
  always_comb begin
    addr_next = addr_reg;
    wd_next   = wd_reg;
    we_next   = we_reg;
    sel_next  = sel_reg;
    pend_next = 1'b0;
    dout_next = dout_reg;
    hit_next  = hit_reg;
    q_next    = q_reg;
    if (clock_en) begin
      addr_next = mem_addr;
      wd_next   = write_word;
      we_next   = write_strobe;
      sel_next  = bank_sel;
      pend_next = 1'b1;
    end
    if (pend_reg) begin
      hit_next = hit_c;
    end
    if (hit_c && !we_reg) begin
      dout_next = rd_word_c;
    end else if (hit_c && we_reg) begin
      unique case (cfg_wm)
        spbm_pkg::WM_NORMAL:            dout_next = dout_reg;
        spbm_pkg::WM_WRITE_THROUGH:     dout_next = wd_masked_c;
        spbm_pkg::WM_READ_BEFORE_WRITE: dout_next = rd_word_c;
      endcase
    end
    // Output stage adds one cycle and obeys the clock enable
    if (!cfg_outstg) begin
      q_next = dout_next;
    end else if (clock_en) begin
      q_next = dout_reg;
    end
    // Synchronous clear: registers only, the array is never touched
    if (cfg_sync && clear_req) begin
      addr_next = '0;
      wd_next   = '0;
      we_next   = 1'b0;
      sel_next  = '0;
      pend_next = 1'b0;
      dout_next = '0;
      hit_next  = 1'b0;
      q_next    = '0;
    end
  end

  // All pipeline flops share the combined asynchronous clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= '0;
      wd_reg   <= '0;
      we_reg   <= 1'b0;
      sel_reg  <= '0;
      pend_reg <= 1'b0;
      dout_reg <= '0;
      hit_reg  <= 1'b0;
      q_reg    <= '0;
    end else begin
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
      we_reg   <= we_next;
      sel_reg  <= sel_next;
      pend_reg <= pend_next;
      dout_reg <= dout_next;
      hit_reg  <= hit_next;
      q_reg    <= q_next;
    end
  end

  assign read_word = q_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_wr_req;
    clock_en && write_strobe && bank_sel == SEL_DECODE && !clear_req;
  endsequence

  sequence s_read_hit;
    hit_c && !we_reg && !clear_req;
  endsequence

  a_wr_after_capture: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_wr_req ##1 !clear_req |-> arr_wr_en)
    else $error("write strobe did not reach the array one cycle later");

  a_direct_read: assert property (
    @(posedge clock) disable iff (!arst_n)
    (s_read_hit and !cfg_outstg) |=> read_word == $past(rd_word_c))
    else $error("direct read data wrong");

  a_staged_read: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_read_hit ##1 (clock_en && !clear_req && cfg_outstg) |=> read_word == $past(rd_word_c, 2))
    else $error("staged read data wrong");

  a_staged_gap: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_read_hit ##1 (!clock_en && !hit_c && !clear_req) ##1 (clock_en && !clear_req && cfg_outstg)
    |=> read_word == $past(rd_word_c, 3))
    else $error("staged read data wrong after an idle edge");

  a_enable_hold: assert property (
    @(posedge clock) disable iff (!arst_n)
    !clock_en && !clear_req |=> $stable(addr_reg) && $stable(wd_reg) && !pend_reg)
    else $error("input registers moved while enable low");

  a_sync_clear: assert property (
    @(posedge clock) disable iff (!arst_n)
    cfg_sync && reg_clear |=> read_word == '0 && !pend_reg && dout_reg == '0)
    else $error("synchronous clear did not empty registers");

  a_async_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    !cfg_sync && reg_clear && $past(reg_clear) && $stable(cfg_sync) |-> read_word == '0)
    else $error("asynchronous clear did not hold output low");

  a_clear_no_write: assert property (
    @(posedge clock) disable iff (!arst_n)
    hit_c && we_reg && clear_req |=> !hit_reg)
    else $error("clear let an access go through");

  a_preset_gate: assert property (
    @(posedge clock) disable iff (!arst_n)
    cfg_sync && !cfg_gsr && global_preset && !reg_clear && clock_en |=> pend_reg)
    else $error("disabled global preset still cleared registers");

  a_bank_miss: assert property (
    @(posedge clock) disable iff (!arst_n)
    pend_reg && sel_reg != SEL_DECODE && !clear_req |-> !arr_wr_en ##1 $stable(dout_reg))
    else $error("access on a foreign bank");

  a_write_through: assert property (
    @(posedge clock) disable iff (!arst_n)
    hit_c && we_reg && cfg_wm == spbm_pkg::WM_WRITE_THROUGH && !clear_req
    |=> dout_reg == $past(wd_masked_c))
    else $error("write-through did not show new word");

  a_normal_write: assert property (
    @(posedge clock) disable iff (!arst_n)
    hit_c && we_reg && cfg_wm == spbm_pkg::WM_NORMAL && !clear_req |=> $stable(dout_reg))
    else $error("normal write changed read data");

  a_read_old: assert property (
    @(posedge clock) disable iff (!arst_n)
    hit_c && we_reg && cfg_wm == spbm_pkg::WM_READ_BEFORE_WRITE && !clear_req
    |=> dout_reg == $past(rd_word_c))
    else $error("read-before-write did not show old word");

endmodule

/* File: verif/spbm_fab.sv */
// Fabric-side model that drives the memory port of the block.
// Assumes the block samples these pins at the rising clock edge.
module spbm_fab (
  // Clock
  input  wire logic   clock,
  // Memory port
  output logic        clock_en,
  output logic        write_strobe,
  output logic [13:0] mem_addr,
  output logic [35:0] write_word,
  output logic [2:0]  bank_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {clock_en, write_strobe, mem_addr, write_word, bank_sel} = '0;
  // Drives a single block, so no outer group decode is needed
  // One enabled edge per request, active-high strobes
  // Data is inverted afterwards so a stale word is never mistaken for a hold
  task automatic req(input logic w, input logic [13:0] a, input logic [35:0] d,
                     input logic [2:0] s);
    @(posedge clock);
    {clock_en, write_strobe, mem_addr, write_word, bank_sel} <= {1'b1, w, a, d, s};
    @(posedge clock);
    {clock_en, write_strobe, write_word} <= {2'b00, ~d};
  endtask
endmodule

/* File: verif/tb_spbm_top.sv */
// Self-checking bench for the single-port block memory.
// Assumes the fabric model drives the memory port; APB is driven here.
module tb_spbm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, rst_n = 0, reg_clear = 0, global_preset = 0, err;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        clock_en, write_strobe;
  logic [13:0] mem_addr;
  logic [35:0] write_word, read_word;
  logic [2:0]  bank_sel;
  int          mismatches = 0, checked = 0;
  always #12.5 clock = ~clock;
  spbm_fab spbm_fab_inst (.clock(clock), .clock_en(clock_en), .write_strobe(write_strobe),
    .mem_addr(mem_addr), .write_word(write_word), .bank_sel(bank_sel));
  spbm_top spbm_top_inst (.clock(clock), .rst_n(rst_n), .clock_en(clock_en),
    .write_strobe(write_strobe), .mem_addr(mem_addr), .write_word(write_word),
    .bank_sel(bank_sel), .read_word(read_word), .reg_clear(reg_clear),
    .global_preset(global_preset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [35:0] e, input logic [35:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      finish_test();
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // Memory request; read data is looked at after the access edge
  task automatic mem(input logic w, input logic [13:0] a, input logic [35:0] d,
                     input logic [2:0] s);
    spbm_fab_inst.req(w, a, d, s);
    @(posedge clock);
    #1;
  endtask
  task automatic s_regs();
    apb(0, spbm_pkg::CFG_OFF, 32'h0);
    cmp("cfg", spbm_pkg::CFG_RESET, rd);
    apb(0, 12'h008, 32'h0);
    cmp("pslverr", 36'h1, err);
  endtask
  // Every write mode, x36 shape, write then read of one place
  task automatic s_modes();
    for (int m = 0; m < 3; m++) begin
      apb(1, spbm_pkg::CFG_OFF, 32'h0000_00A4 | (m << 3));
      mem(1, 14'h0001, 36'h1_2345_6780 + m, 3'h0);
      mem(0, 14'h0001, 36'h0, 3'h0);
      cmp("read", 36'h1_2345_6780 + m, read_word);
      mem(1, 14'h0001, 36'hA_BCDE_F010 + m, 3'h0);
      cmp("wmode", (m == 1) ? 36'hA_BCDE_F010 + m : 36'h1_2345_6780 + m, read_word);
    end
  endtask
  task automatic s_bank();
    mem(1, 14'h0001, 36'h0_0000_0055, 3'h1);
    cmp("miss", 36'h1_2345_6782, read_word);
    mem(0, 14'h0001, 36'h0, 3'h0);
    cmp("bank", 36'hA_BCDE_F012, read_word);
  endtask
  // Clears empty the output at once but never the array
  task automatic s_clear();
    @(posedge clock);
    reg_clear <= 1'b1;
    #1;
    cmp("clear", 36'h0, read_word);
    repeat (2) @(posedge clock);
    reg_clear <= 1'b0;
    mem(0, 14'h0001, 36'h0, 3'h0);
    @(posedge clock);
    global_preset <= 1'b1;
    #1;
    cmp("preset", 36'h0, read_word);
    @(posedge clock);
    global_preset <= 1'b0;
    mem(0, 14'h0001, 36'h0, 3'h0);
    cmp("kept", 36'hA_BCDE_F012, read_word);
  endtask
  task automatic s_shape();
    apb(1, spbm_pkg::CFG_OFF, 32'h0000_0004);
    mem(1, 14'h0005, 36'hF_FFFF_FFFF, 3'h0);
    mem(0, 14'h0005, 36'h0, 3'h0);
    cmp("x1", 36'h1, read_word);
    mem(0, 14'h0004, 36'h0, 3'h0);
    cmp("x1 zero", 36'h0, read_word);
  endtask
  // Staged output, preset disabled, synchronous clear and a cancelled write
  task automatic s_sync();
    apb(1, spbm_pkg::CFG_OFF, 32'h0000_00A3);
    mem(0, 14'h0001, 36'h0, 3'h0);
    cmp("stage wait", 36'h0, read_word);
    mem(0, 14'h0000, 36'h0, 3'h0);
    cmp("staged", 36'hA_BCDE_F012, read_word);
    @(posedge clock);
    global_preset <= 1'b1;
    mem(0, 14'h0001, 36'h0, 3'h0);
    cmp("preset off", 36'h0_0000_0020, read_word);
    @(posedge clock);
    global_preset <= 1'b0;
    reg_clear <= 1'b1;
    #1;
    cmp("sync wait", 36'h0_0000_0020, read_word);
    @(posedge clock);
    reg_clear <= 1'b0;
    #1;
    cmp("sync clear", 36'h0, read_word);
    // Clear lands on the access edge of a write, which must then be dropped
    fork
      spbm_fab_inst.req(1, 14'h0001, 36'h5_5555_5555, 3'h0);
      begin
        repeat (2) @(posedge clock);
        reg_clear <= 1'b1;
        @(posedge clock);
        reg_clear <= 1'b0;
      end
    join
    mem(0, 14'h0001, 36'h0, 3'h0);
    mem(0, 14'h0000, 36'h0, 3'h0);
    cmp("cancel", 36'hA_BCDE_F012, read_word);
  endtask
  // Each remaining shape returns only its own width
  task automatic s_widths();
    logic [35:0] e [4];
    e = '{spbm_pkg::MASK_X2, spbm_pkg::MASK_X4, spbm_pkg::MASK_X9, spbm_pkg::MASK_X18};
    for (int sh = 1; sh < 5; sh++) begin
      apb(1, spbm_pkg::CFG_OFF, 32'h0000_0004 | (sh << 5));
      mem(1, 14'h0003, 36'hF_FFFF_FFFF, 3'h0);
      mem(0, 14'h0003, 36'h0, 3'h0);
      cmp("width", e[sh-1], read_word);
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    s_regs();
    s_modes();
    s_bank();
    s_clear();
    s_shape();
    s_sync();
    s_widths();
    finish_test();
  end
endmodule
